// [vsp_pkg.sv]
// Shared constants for the video sync processor
package vsp_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int CLK_NS = 40;
  localparam int SEP_UNIT_NS = 200;
  localparam int SEP_UNIT_CYC = (SEP_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_UNIT_NS = 25;
  localparam int WIN_UNIT_CYC = (WIN_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHASE_STEPS = 32;
  localparam int PHASE_STEP_MDEG = 11250;

  localparam logic [IDX_W-1:0] IDX_SEP_THRESH = 10'h011;
  localparam logic [IDX_W-1:0] IDX_HS_CTL = 10'h012;
  localparam logic [IDX_W-1:0] IDX_VF_CTL = 10'h014;
  localparam logic [IDX_W-1:0] IDX_PRECOAST = 10'h016;
  localparam logic [IDX_W-1:0] IDX_POSTCOAST = 10'h017;
  localparam logic [IDX_W-1:0] IDX_COAST_CTL = 10'h018;
  localparam logic [IDX_W-1:0] IDX_SLICE_LVL = 10'h01d;
  localparam logic [IDX_W-1:0] IDX_SYNC_SEL = 10'h020;
  localparam logic [IDX_W-1:0] IDX_FILT_WIN = 10'h023;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h025;
  localparam logic [IDX_W-1:0] IDX_LINE_TOTAL = 10'h026;
  localparam logic [IDX_W-1:0] IDX_PUMP = 10'h030;
  localparam logic [IDX_W-1:0] IDX_PHASE = 10'h031;
  localparam logic [IDX_W-1:0] IDX_DIVISOR = 10'h032;

  localparam int HS_POL_LSB = 4;
  localparam int COAST_POL_LSB = 5;
  localparam int COAST_EXT_BIT = 7;
  localparam int VF_EN_BIT = 2;
  localparam int CS_SLICER_BIT = 3;
  localparam int SLICE_LSB = 3;
  localparam int PLLREF_FILT_BIT = 2;
  localparam int PROC_REGEN_BIT = 1;
  localparam int EXTRA_BIT = 1;
  localparam logic [1:0] POL_ACTIVE_HIGH = 2'h1;

  localparam logic [7:0] RST_SEP_THRESH = 8'h20;
  localparam logic [7:0] RST_HS_CTL = 8'h10;
  localparam logic [7:0] RST_VF_CTL = 8'h04;
  localparam logic [7:0] RST_PRECOAST = 8'h02;
  localparam logic [7:0] RST_POSTCOAST = 8'h0a;
  localparam logic [7:0] RST_COAST_CTL = 8'h20;
  localparam logic [7:0] RST_SLICE_LVL = 8'h78;
  localparam logic [7:0] RST_SYNC_SEL = 8'h06;
  localparam logic [7:0] RST_FILT_WIN = 8'h0a;
  localparam logic [2:0] RST_PUMP = 3'h5;
  localparam logic [11:0] RST_DIVISOR = 12'h320;
  localparam logic [11:0] DIV_MIN = 12'h002;

  function automatic logic [10:0] pump_ua(input logic [2:0] code);
    case (code)
      3'h0: pump_ua = 11'd50;
      3'h1: pump_ua = 11'd100;
      3'h2: pump_ua = 11'd150;
      3'h3: pump_ua = 11'd250;
      3'h4: pump_ua = 11'd350;
      3'h5: pump_ua = 11'd500;
      3'h6: pump_ua = 11'd750;
      default: pump_ua = 11'd1500;
    endcase
  endfunction
endpackage

// [vsp_line_if.sv]
// Line sync signals between the core and the line filter
`timescale 1ns/1ps
interface vsp_line_if;
  logic raw_edge;
  logic [7:0] window;
  logic regen_edge;
  logic regen_level;
  logic filt_edge;
  logic extra;
  logic mid_line;
  logic first_half;
  modport filt (input raw_edge, window,
    output regen_edge, regen_level, filt_edge, extra, mid_line, first_half);
  modport core (output raw_edge, window,
    input regen_edge, regen_level, filt_edge, extra, mid_line, first_half);
endinterface

// [vsp_line_filter.sv]
// Line sync regenerator and windowed line sync filter
`timescale 1ns/1ps
module vsp_line_filter #(
  parameter int CNT_W = 16,
  parameter int REGEN_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  vsp_line_if.filt lif
);
  import vsp_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic [7:0] pulse;
    logic regen_edge;
    logic filt_edge;
    logic extra;
    logic mid;
    logic first_half;
  } vsp_filt_state_type;

  vsp_filt_state_type st;
  vsp_filt_state_type nxt;
  logic [CNT_W-1:0] win;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] late;
  logic near;
  logic regen;

  always_comb begin
    nxt = st;
    win = CNT_W'(lif.window * WIN_UNIT_CYC);
    half = st.period >> 1;
    late = st.period + (st.period >> 3);
    // Window of +/- win around the predicted leading edge
    near = (({1'b0, st.cnt} + {1'b0, win}) >= {1'b0, st.period}) || (st.cnt <= win);
    regen = 1'b0;
    nxt.cnt = st.cnt + 1'b1;
    if (lif.raw_edge && (st.cnt >= half)) begin
      // Edges in the first half line are extraneous and ignored here
      regen = 1'b1;
      nxt.cnt = '0;
      if (!st.cnt[CNT_W-1]) begin
        nxt.period = st.cnt;
      end
    end else if (st.cnt >= late) begin
      // Missing edge: flywheel supplies the line
      regen = 1'b1;
      nxt.cnt = '0;
    end
    nxt.regen_edge = regen;
    nxt.filt_edge = lif.raw_edge && near;
    nxt.extra = lif.raw_edge && !near;
    if (regen) begin
      nxt.pulse = 8'(REGEN_W);
    end else if (st.pulse != 8'h00) begin
      nxt.pulse = st.pulse - 8'h01;
    end
    nxt.mid = (st.cnt == half);
    nxt.first_half = (st.cnt < half);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.period <= CNT_W'(1) << (CNT_W - 2);
    end else begin
      st <= nxt;
    end
  end

  assign lif.regen_edge = st.regen_edge;
  assign lif.regen_level = (st.pulse != 8'h00);
  assign lif.filt_edge = st.filt_edge;
  assign lif.extra = st.extra;
  assign lif.mid_line = st.mid;
  assign lif.first_half = st.first_half;
endmodule

// [vsp_sync_core.sv]
// Sync processing and clock generator control with APB registers
// Overview of operation
// - 3-bit code selects charge-pump current
// - 5-bit phase gives 32 steps of 11.25 degrees
// - Line sync output gets same phase shift
// - Phase works with external pixel clock too
// - Coast holds PLL frequency, reference ignored
// - Coast polarity field, value 1 active high
// - Line sync polarity field, value 1 active high
// - Internal coast timed from frame sync
// - Slicer compares green sync to trigger level
// - Separator source is slicer or line input
// - Separator rejects short pulses, passes long
// - Threshold is N times 200 ns
// - Separated frame sync delayed by threshold
// - Regenerator rebuilds line sync without setup
// - Filter window plus/minus x times 25 ns; code rounds the unit up to one 40 ns clock
// - Window repeats each line, outsiders discarded
// - Status flag reports extraneous pulses seen
// - Select filtered or raw PLL reference
// - Select regenerated or raw processing sync
// - Frame filter deglitches, avoids line edges, fields
// - Frame filter enable, needed for line count
// - Produce reference, field, syncs, count, sliced
// - Divisor 12 bits, 2 to 4095 only
// - Internal coast spans precoast and postcoast lines
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module vsp_sync_core #(
  parameter int CNT_W = 16,
  parameter int REGEN_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vsp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] green_sync_input,
  input wire logic line_sync_input,
  input wire logic coast_input,
  input wire logic ext_clock_sel,
  output logic sliced_sync_output,
  output logic line_sync_output,
  output logic frame_sync_output,
  output logic field_odd,
  output logic pll_ref,
  output logic pll_coast,
  output logic pll_clock_select,
  output logic [11:0] pll_divisor,
  output logic pump_current_bit2,
  output logic pump_current_bit1,
  output logic pump_current_bit0,
  output logic [10:0] pump_current_ua,
  output logic [4:0] sample_phase,
  output logic [18:0] sample_phase_mdeg
);
  import vsp_pkg::*;

  typedef struct packed {
    logic [7:0] sep_thresh;
    logic [7:0] hs_ctl;
    logic [7:0] vf_ctl;
    logic [7:0] precoast;
    logic [7:0] postcoast;
    logic [7:0] coast_ctl;
    logic [7:0] slice_lvl;
    logic [7:0] sync_sel;
    logic [7:0] filt_win;
    logic extra_flag;
    logic [2:0] pump;
    logic [4:0] phase;
    logic [11:0] divisor;
    logic [31:0] prdata;
    logic slverr;
    logic [2:0] hs_s;
    logic [2:0] co_s;
    logic hs_st;
    logic co_st;
    logic [7:0] neg_peak;
    logic slice;
    logic cs_prev;
    logic [10:0] sep_cnt;
    logic vs_sep;
    logic vs_sep_prev;
    logic vs_cand;
    logic vs_filt;
    logic vs_late;
    logic odd;
    logic [11:0] line_cnt;
    logic [11:0] lines_total;
    logic coast;
    logic ref_pulse;
    logic [PHASE_STEPS-1:0] dly;
    logic [10:0] pump_ua_ff;
    logic [18:0] phase_mdeg;
  } vsp_core_state_type;

  vsp_core_state_type st;
  vsp_core_state_type nxt;
  vsp_line_if lif();

  logic [IDX_W-1:0] idx;
  logic wr;
  logic hs_act;
  logic co_act;
  logic cs;
  logic [8:0] slice_level;
  logic [10:0] thr_cyc;
  logic proc_lvl;
  logic proc_edge;
  logic coast_int;
  logic [11:0] pre_start;

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] i;
    i = addr[ADDR_W-1:2];
    reg_mapped = (addr[1:0] == 2'h0) &&
      ((i == IDX_SEP_THRESH) || (i == IDX_HS_CTL) || (i == IDX_VF_CTL) ||
       (i == IDX_PRECOAST) || (i == IDX_POSTCOAST) || (i == IDX_COAST_CTL) ||
       (i == IDX_SLICE_LVL) || (i == IDX_SYNC_SEL) || (i == IDX_FILT_WIN) ||
       (i == IDX_STATUS) || (i == IDX_LINE_TOTAL) || (i == IDX_PUMP) ||
       (i == IDX_PHASE) || (i == IDX_DIVISOR));
  endfunction

  vsp_line_filter #(
    .CNT_W(CNT_W),
    .REGEN_W(REGEN_W)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .lif(lif.filt)
  );

  assign lif.raw_edge = cs && !st.cs_prev;
  assign lif.window = st.filt_win;

  always_comb begin
    nxt = st;
    idx = paddr[ADDR_W-1:2];
    // Pins settle once the second and third stages agree
    nxt.hs_s = {st.hs_s[1:0], line_sync_input};
    nxt.co_s = {st.co_s[1:0], coast_input};
    if (st.hs_s[1] == st.hs_s[2]) begin
      nxt.hs_st = st.hs_s[2];
    end
    if (st.co_s[1] == st.co_s[2]) begin
      nxt.co_st = st.co_s[2];
    end
    hs_act = (st.hs_ctl[HS_POL_LSB+:2] == POL_ACTIVE_HIGH) ? st.hs_st : !st.hs_st;
    co_act = (st.coast_ctl[COAST_POL_LSB+:2] == POL_ACTIVE_HIGH) ? st.co_st : !st.co_st;

    // Slicer: negative peak clamp plus trigger level; the peak leaks up once a line
    slice_level = {1'b0, st.neg_peak} + {4'h0, st.slice_lvl[SLICE_LSB+:5]};
    if (green_sync_input < st.neg_peak) begin
      nxt.neg_peak = green_sync_input;
    end else if (lif.regen_edge && (st.neg_peak != 8'hff)) begin
      nxt.neg_peak = st.neg_peak + 8'h01;
    end
    nxt.slice = ({1'b0, green_sync_input} <= slice_level);
    cs = st.vf_ctl[CS_SLICER_BIT] ? st.slice : hs_act;
    nxt.cs_prev = cs;

    // Separator counts the active composite width against the threshold
    thr_cyc = 11'(st.sep_thresh * SEP_UNIT_CYC);
    if (cs) begin
      if (st.sep_cnt != 11'h7ff) begin
        nxt.sep_cnt = st.sep_cnt + 11'h001;
      end
      nxt.vs_sep = (st.sep_cnt >= thr_cyc);
    end else begin
      nxt.sep_cnt = 11'h000;
      nxt.vs_sep = 1'b0;
    end
    nxt.vs_sep_prev = st.vs_sep;

    // Frame filter: changes only at mid line, after two agreeing samples
    if (st.vf_ctl[VF_EN_BIT]) begin
      if (st.vs_sep && !st.vs_sep_prev) begin
        nxt.vs_late = !lif.first_half;
      end
      if (lif.mid_line) begin
        nxt.vs_cand = st.vs_sep;
        if (st.vs_cand == st.vs_sep) begin
          nxt.vs_filt = st.vs_sep;
          if (st.vs_sep && !st.vs_filt) begin
            nxt.odd = st.vs_late;
          end
        end
      end
    end else begin
      nxt.vs_filt = st.vs_sep;
      nxt.vs_cand = st.vs_sep;
    end

    proc_lvl = st.sync_sel[PROC_REGEN_BIT] ? lif.regen_level : cs;
    proc_edge = st.sync_sel[PROC_REGEN_BIT] ? lif.regen_edge : lif.raw_edge;
    nxt.dly = {st.dly[PHASE_STEPS-2:0], proc_lvl};

    // Line count per frame is only exact with the frame filter enabled
    if (nxt.vs_filt && !st.vs_filt) begin
      nxt.lines_total = st.line_cnt;
      nxt.line_cnt = 12'h000;
    end else if (proc_edge && (st.line_cnt != 12'hfff)) begin
      nxt.line_cnt = st.line_cnt + 12'h001;
    end

    pre_start = st.lines_total - {4'h0, st.precoast};
    coast_int = ((st.lines_total > {4'h0, st.precoast}) && (st.line_cnt >= pre_start)) ||
      (st.line_cnt < {4'h0, st.postcoast});
    nxt.coast = st.coast_ctl[COAST_EXT_BIT] ? co_act : coast_int;
    if (nxt.coast) begin
      nxt.ref_pulse = 1'b0;
    end else if (st.sync_sel[PLLREF_FILT_BIT]) begin
      nxt.ref_pulse = lif.filt_edge;
    end else begin
      nxt.ref_pulse = lif.raw_edge;
    end

    nxt.pump_ua_ff = pump_ua(st.pump);
    nxt.phase_mdeg = 19'(st.phase * PHASE_STEP_MDEG);

    // Read data is fetched in the setup phase
    if (psel && !penable) begin
      nxt.slverr = !reg_mapped(paddr);
      nxt.prdata = 32'h0000_0000;
      if (idx == IDX_SEP_THRESH) begin
        nxt.prdata[7:0] = st.sep_thresh;
      end else if (idx == IDX_HS_CTL) begin
        nxt.prdata[7:0] = st.hs_ctl;
      end else if (idx == IDX_VF_CTL) begin
        nxt.prdata[7:0] = st.vf_ctl;
      end else if (idx == IDX_PRECOAST) begin
        nxt.prdata[7:0] = st.precoast;
      end else if (idx == IDX_POSTCOAST) begin
        nxt.prdata[7:0] = st.postcoast;
      end else if (idx == IDX_COAST_CTL) begin
        nxt.prdata[7:0] = st.coast_ctl;
      end else if (idx == IDX_SLICE_LVL) begin
        nxt.prdata[7:0] = st.slice_lvl;
      end else if (idx == IDX_SYNC_SEL) begin
        nxt.prdata[7:0] = st.sync_sel;
      end else if (idx == IDX_FILT_WIN) begin
        nxt.prdata[7:0] = st.filt_win;
      end else if (idx == IDX_STATUS) begin
        nxt.prdata[EXTRA_BIT] = st.extra_flag;
      end else if (idx == IDX_LINE_TOTAL) begin
        nxt.prdata[11:0] = st.lines_total;
      end else if (idx == IDX_PUMP) begin
        nxt.prdata[2:0] = st.pump;
      end else if (idx == IDX_PHASE) begin
        nxt.prdata[4:0] = st.phase;
      end else if (idx == IDX_DIVISOR) begin
        nxt.prdata[11:0] = st.divisor;
      end
    end

    wr = psel && penable && pwrite && !st.slverr;
    if (wr) begin
      if (idx == IDX_SEP_THRESH) begin
        nxt.sep_thresh = pwdata[7:0];
      end else if (idx == IDX_HS_CTL) begin
        nxt.hs_ctl = pwdata[7:0];
      end else if (idx == IDX_VF_CTL) begin
        nxt.vf_ctl = pwdata[7:0];
      end else if (idx == IDX_PRECOAST) begin
        nxt.precoast = pwdata[7:0];
      end else if (idx == IDX_POSTCOAST) begin
        nxt.postcoast = pwdata[7:0];
      end else if (idx == IDX_COAST_CTL) begin
        nxt.coast_ctl = pwdata[7:0];
      end else if (idx == IDX_SLICE_LVL) begin
        nxt.slice_lvl = pwdata[7:0];
      end else if (idx == IDX_SYNC_SEL) begin
        nxt.sync_sel = pwdata[7:0];
      end else if (idx == IDX_FILT_WIN) begin
        nxt.filt_win = pwdata[7:0];
      end else if (idx == IDX_STATUS) begin
        if (pwdata[EXTRA_BIT]) begin
          nxt.extra_flag = 1'b0;
        end
      end else if (idx == IDX_PUMP) begin
        nxt.pump = pwdata[2:0];
      end else if (idx == IDX_PHASE) begin
        nxt.phase = pwdata[4:0];
      end else if (idx == IDX_DIVISOR) begin
        // Divisors below the minimum are ignored
        if (pwdata[11:0] >= DIV_MIN) begin
          nxt.divisor = pwdata[11:0];
        end
      end
    end
    // A new extraneous pulse wins over a clear in the same cycle
    if (lif.extra) begin
      nxt.extra_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.sep_thresh <= RST_SEP_THRESH;
      st.hs_ctl <= RST_HS_CTL;
      st.vf_ctl <= RST_VF_CTL;
      st.precoast <= RST_PRECOAST;
      st.postcoast <= RST_POSTCOAST;
      st.coast_ctl <= RST_COAST_CTL;
      st.slice_lvl <= RST_SLICE_LVL;
      st.sync_sel <= RST_SYNC_SEL;
      st.filt_win <= RST_FILT_WIN;
      st.pump <= RST_PUMP;
      st.divisor <= RST_DIVISOR;
      st.neg_peak <= 8'hff;
    end else begin
      st <= nxt;
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && st.slverr;
  assign prdata = st.prdata;
  assign sliced_sync_output = st.slice;
  assign line_sync_output = st.dly[st.phase];
  assign frame_sync_output = st.vs_filt;
  assign field_odd = st.odd;
  assign pll_ref = st.ref_pulse;
  assign pll_coast = st.coast;
  assign pll_clock_select = ext_clock_sel;
  assign pll_divisor = st.divisor;
  assign pump_current_bit2 = st.pump[2];
  assign pump_current_bit1 = st.pump[1];
  assign pump_current_bit0 = st.pump[0];
  assign pump_current_ua = st.pump_ua_ff;
  assign sample_phase = st.phase;
  assign sample_phase_mdeg = st.phase_mdeg;

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pump_top_code: assert property ((st.pump == 3'h7) |=> (pump_current_ua == 11'd1500))
    else $error("pump current wrong for top code");
  a_phase_zero_tap: assert property ((st.phase == 5'h00) |-> (line_sync_output == $past(proc_lvl)))
    else $error("line sync not shifted by phase");
  a_coast_blocks_ref: assert property (pll_coast |-> !pll_ref)
    else $error("reference passed during coast");
  a_ext_coast_pol: assert property ((st.coast_ctl[COAST_EXT_BIT] && $past(st.coast_ctl[COAST_EXT_BIT])
    && st.coast_ctl[COAST_POL_LSB+:2] == POL_ACTIVE_HIGH) |-> (pll_coast == $past(st.co_st)))
    else $error("external coast polarity wrong");
  a_sep_rejects_short: assert property (!cs |=> !st.vs_sep)
    else $error("separator passed inactive sync");
  a_sep_threshold: assert property ($rose(st.vs_sep) |-> ($past(st.sep_cnt) >= $past(thr_cyc)))
    else $error("separated sync before threshold");
  a_extra_sticky: assert property (lif.extra |=> st.extra_flag)
    else $error("extraneous pulse not flagged");
  a_vf_mid_line: assert property ((st.vf_ctl[VF_EN_BIT] && $past(st.vf_ctl[VF_EN_BIT])
    && $changed(st.vs_filt)) |-> $past(lif.mid_line))
    else $error("frame sync moved off mid line");
  a_divisor_floor: assert property (pll_divisor >= DIV_MIN)
    else $error("divisor below minimum");
  a_ref_filtered: assert property ((!nxt.coast && st.sync_sel[PLLREF_FILT_BIT]) |=> (pll_ref == $past(lif.filt_edge)))
    else $error("filtered reference not selected");
  c_frame_seen: cover property ($rose(frame_sync_output));
  c_extra_seen: cover property ($rose(st.extra_flag));
  c_coast_seen: cover property ($rose(pll_coast));
  c_divisor_write: cover property (wr && idx == IDX_DIVISOR);
endmodule

// [vsp_sync_source.sv]
// Video source model: line sync, frame pulse, extra pulses and green samples
`timescale 1ns/1ps
module vsp_sync_source #(
  parameter int LINE = 64,
  parameter int WID = 8
) (
  input wire logic pclk,
  input wire logic run,
  input wire logic frame_req,
  input wire logic extra_req,
  output logic line_sync,
  output logic [7:0] green
);
  int pos = 0;
  logic s;
  initial begin
    line_sync = 1'b0;
    green = 8'h80;
  end
  always @(posedge pclk) begin
    pos <= (pos == LINE - 1) ? 0 : pos + 1;
  end
  // Extra pulses sit early in the line, long pulse carries frame sync
  assign s = run && (pos < WID || frame_req || (extra_req && pos >= 16 && pos < 20));
  always @(posedge pclk) begin
    line_sync <= s;
    // Sync tip sits at the negative peak of green
    green <= s ? 8'h10 : 8'h80;
  end
endmodule

// [testbench.sv]
// Self-checking bench for the video sync processor
`timescale 1ns/1ps
module testbench;
  import vsp_pkg::*;
  localparam int LINE = 64;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, line_sync_input, sliced_sync_output, line_sync_output;
  logic frame_sync_output, field_odd, pll_ref, pll_coast, pll_clock_select;
  logic pump_current_bit2, pump_current_bit1, pump_current_bit0;
  logic [7:0] green_sync_input;
  logic [11:0] pll_divisor;
  logic [10:0] pump_current_ua;
  logic [4:0] sample_phase;
  logic [18:0] sample_phase_mdeg;
  logic coast_input = 1'b0;
  logic ext_clock_sel = 1'b0;
  logic run = 1'b0;
  logic frame_req = 1'b0;
  logic extra_req = 1'b0;
  logic clr = 1'b0;
  logic frame_seen = 1'b0;
  logic slice_seen = 1'b0;
  logic [31:0] q;
  logic err;
  logic [IDX_W-1:0] ridx [12];
  logic [11:0] rval [12];
  int ua_tab [8] = '{50, 100, 150, 250, 350, 500, 750, 1500};
  int ref_cnt = 0;
  int hs_cnt = 0;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #20 pclk = ~pclk;

  vsp_sync_source #(.LINE(LINE)) i_src (.pclk, .run, .frame_req, .extra_req,
    .line_sync(line_sync_input), .green(green_sync_input));

  vsp_sync_core #(.CNT_W(10)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .green_sync_input, .line_sync_input, .coast_input,
    .ext_clock_sel, .sliced_sync_output, .line_sync_output, .frame_sync_output, .field_odd,
    .pll_ref, .pll_coast, .pll_clock_select, .pll_divisor, .pump_current_bit2,
    .pump_current_bit1, .pump_current_bit0, .pump_current_ua, .sample_phase,
    .sample_phase_mdeg);

  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer followed by two idle cycles so registered outputs settle
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Restart the monitors, then watch the given number of lines
  task automatic watch(input int lines);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (lines * LINE + 1) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (clr) begin
      frame_seen <= 1'b0;
      slice_seen <= 1'b0;
      ref_cnt <= 0;
      hs_cnt <= 0;
    end else begin
      if (line_sync_output === 1'b1) hs_cnt <= hs_cnt + 1;
      if (frame_sync_output === 1'b1) frame_seen <= 1'b1;
      if (sliced_sync_output === 1'b1) slice_seen <= 1'b1;
      if (pll_ref === 1'b1) ref_cnt <= ref_cnt + 1;
    end
    if (cycles == 12000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    ridx = '{IDX_SEP_THRESH, IDX_HS_CTL, IDX_VF_CTL, IDX_PRECOAST, IDX_POSTCOAST,
      IDX_COAST_CTL, IDX_SLICE_LVL, IDX_SYNC_SEL, IDX_FILT_WIN, IDX_STATUS, IDX_PUMP, IDX_DIVISOR};
    rval = '{12'h20, 12'h10, 12'h04, 12'h02, 12'h0a, 12'h20, 12'h78, 12'h06, 12'h0a,
      12'h0, 12'h5, 12'h320};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, ridx[i], 32'h0);
      chk("reset_value", 32'(rval[i]), q);
    end
    apb(1'b0, 10'h3ff, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, q);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_PUMP, 32'(c));
      chk("pump_bits", 32'(c), {29'h0, pump_current_bit2, pump_current_bit1,
        pump_current_bit0});
      chk("pump_ua", 32'(ua_tab[c]), 32'(pump_current_ua));
    end
    ext_clock_sel <= 1'b1;
    apb(1'b1, IDX_PHASE, 32'h1f);
    chk("sample_phase", 32'h1f, 32'(sample_phase));
    chk("phase_mdeg", 32'd348750, 32'(sample_phase_mdeg));
    chk("clock_select", 32'h1, 32'(pll_clock_select));
    ext_clock_sel <= 1'b0;
    apb(1'b1, IDX_DIVISOR, 32'h1);
    chk("divisor_below_min", 32'h320, 32'(pll_divisor));
    apb(1'b1, IDX_DIVISOR, 32'h2);
    chk("divisor_min", 32'h2, 32'(pll_divisor));
    apb(1'b1, IDX_DIVISOR, 32'hfff);
    chk("divisor_max", 32'hfff, 32'(pll_divisor));
    apb(1'b1, IDX_SEP_THRESH, 32'h4);
    apb(1'b1, IDX_FILT_WIN, 32'h6);
    apb(1'b0, IDX_SEP_THRESH, 32'h0);
    chk("sep_threshold", 32'h4, q);
    apb(1'b0, IDX_FILT_WIN, 32'h0);
    chk("filter_window", 32'h6, q);
    run <= 1'b1;
    repeat (12 * LINE) @(posedge pclk);
    apb(1'b1, IDX_STATUS, 32'h2);
    watch(8);
    chk("frame_short_pulses", 32'h0, 32'(frame_seen));
    chk("sliced_sync", 32'h1, 32'(slice_seen));
    chk("ref_clean", 32'd8, 32'(ref_cnt));
    // Eight regenerated pulses of eight cycles each, phase-delayed
    chk("line_sync_out", 32'd64, 32'(hs_cnt));
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("extra_flag_clear", 32'h0, q & 32'h2);
    extra_req <= 1'b1;
    watch(8);
    chk("ref_filtered", 32'd8, 32'(ref_cnt));
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("extra_flag_set", 32'h2, q & 32'h2);
    apb(1'b1, IDX_SYNC_SEL, 32'h2);
    watch(8);
    chk("ref_raw", 32'd16, 32'(ref_cnt));
    extra_req <= 1'b0;
    apb(1'b1, IDX_SYNC_SEL, 32'h6);
    // Let extra pulses already in the pin synchroniser drain before the clear
    repeat (LINE) @(posedge pclk);
    apb(1'b1, IDX_STATUS, 32'h2);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("extra_flag_w1c", 32'h0, q & 32'h2);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    frame_req <= 1'b1;
    repeat (3 * LINE) @(posedge pclk);
    frame_req <= 1'b0;
    repeat (4 * LINE) @(posedge pclk);
    chk("frame_long_pulse", 32'h1, 32'(frame_seen));
    apb(1'b1, IDX_COAST_CTL, 32'ha0);
    coast_input <= 1'b1;
    repeat (8) @(posedge pclk);
    watch(2);
    chk("coast_active_high", 32'h1, 32'(pll_coast));
    chk("ref_during_coast", 32'h0, 32'(ref_cnt));
    apb(1'b1, IDX_COAST_CTL, 32'h80);
    chk("coast_active_low_idle", 32'h0, 32'(pll_coast));
    coast_input <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("coast_active_low", 32'h1, 32'(pll_coast));
    // Idle line input read as active low becomes one long composite pulse
    run <= 1'b0;
    apb(1'b1, IDX_HS_CTL, 32'h00);
    repeat (6 * LINE) @(posedge pclk);
    chk("line_pol_low", 32'h1, 32'(frame_sync_output));
    apb(1'b1, IDX_HS_CTL, 32'h10);
    repeat (6 * LINE) @(posedge pclk);
    chk("line_pol_high", 32'h0, 32'(frame_sync_output));
    give_verdict();
  end
endmodule
